/* File: cos_clock_output_startup_control.v */
// start-up timer, glitch-free clock output divider and led polarity sensing
`include "cos_clock_output_startup_control_map.vh"

module cos_clock_output_startup_control #(
   parameter OSC_RATIO = `COS_CLK_HZ / `COS_OSC_HZ,
   parameter STARTUP_CYC = `COS_SUT_OSC_CYCLES * (`COS_CLK_HZ / `COS_OSC_HZ),
   parameter STRETCH_CYC = 2000000,
   parameter BLINK_W = 24
) (
   input wire clk, // clock
   input wire rst, // power-on reset, sync, high
   input wire sys_rst, // pin or software reset, sync, high
   input wire power_down, // power-down mode level
   input wire ccon_wr, // clock output control write strobe
   input wire [7:0] ccon_wdata, // clock output control write data
   output wire [7:0] ccon_rdata, // clock output control read data
   output wire clock_ready_flag, // startup timer expired
   output wire clock_output_pin, // divided clock output
   input wire [3:0] first_led_config, // first led config field
   input wire [3:0] second_led_config, // second led config field
   input wire tx_activity, // transmit activity pulse
   input wire rx_activity, // receive activity pulse
   input wire stretch_en, // stretch activity display
   input wire first_led_pin_i, // first led pin level
   output wire first_led_pin_o, // first led pin drive
   output wire first_led_pin_oe, // first led pin enable
   input wire second_led_pin_i, // second led pin level
   output wire second_led_pin_o, // second led pin drive
   output wire second_led_pin_oe, // second led pin enable
   output wire duplex_mode_bit // full duplex when high
);

   localparam [31:0] GAP_CYC = `COS_GAP_OSC_CYCLES * OSC_RATIO;
   localparam [31:0] SUT_LAST = STARTUP_CYC - 1;

   // half period of the output, in clk cycles
   function [7:0] half_cyc;
      input [2:0] sel;
      reg [7:0] div;
      begin
         div = `COS_DIV1;
         case (sel)
            `COS_SEL_DIV1: div = `COS_DIV1;
            `COS_SEL_DIV2: div = `COS_DIV2;
            `COS_SEL_DIV3: div = `COS_DIV3;
            `COS_SEL_DIV4: div = `COS_DIV4;
            `COS_SEL_DIV8: div = `COS_DIV8;
            default: div = `COS_DIV1;
         endcase
         half_cyc = div * OSC_RATIO[7:0] / 8'h02;
      end
   endfunction

   // codes that run the divider
   function sel_valid;
      input [2:0] sel;
      begin
         sel_valid = (sel != `COS_SEL_OFF) && (sel <= `COS_SEL_DIV8);
      end
   endfunction

   // led lit state for one config field
   function led_lit;
      input [3:0] cfg;
      input act;
      input fast;
      input slow;
      begin
         case (cfg)
            `COS_LED_ACT: led_lit = act;
            `COS_LED_ON: led_lit = 1'b1;
            `COS_LED_OFF: led_lit = 1'b0;
            `COS_LED_FAST: led_lit = fast;
            `COS_LED_SLOW: led_lit = slow;
            default: led_lit = 1'b0;
         endcase
      end
   endfunction

   // ---------------- register and startup timer ----------------
   reg [2:0] sel_ff;
   reg [7:0] rdata_ff;
   reg [31:0] sut_cnt_ff;
   reg sut_run_ff;
   reg ready_ff;
   // set by the first expiry only, so a wake never restarts the output
   reg started_ff;
   reg pd_ff;
   // timer only pauses while asleep; the restart comes on exit
   wire pd_exit = pd_ff & ~power_down;
   wire sut_expire = sut_run_ff && (sut_cnt_ff == SUT_LAST);

   // sys_rst deliberately absent: control survives pin and software reset
   always @(posedge clk) begin
      if (rst) begin
         sel_ff <= `COS_SEL_RESET;
         rdata_ff <= {`COS_CTRL_PAD, `COS_SEL_RESET};
      end else if (ccon_wr) begin
         sel_ff <= ccon_wdata[2:0];
         rdata_ff <= {`COS_CTRL_PAD, ccon_wdata[2:0]};
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         sut_cnt_ff <= 32'h00000000;
         sut_run_ff <= 1'b1;
         ready_ff <= 1'b0;
         started_ff <= 1'b0;
         pd_ff <= 1'b0;
      end else begin
         pd_ff <= power_down;
         if (pd_exit) begin
            sut_cnt_ff <= 32'h00000000;
            sut_run_ff <= 1'b1;
            ready_ff <= 1'b0;
         end else if (sut_expire) begin
            sut_run_ff <= 1'b0;
            ready_ff <= 1'b1;
            started_ff <= 1'b1;
         end else if (sut_run_ff && !power_down) begin
            sut_cnt_ff <= sut_cnt_ff + 32'h00000001;
         end
      end
   end

   // ---------------- glitch-free clock output ----------------
   reg [1:0] st_ff;
   reg [1:0] nxt_st;
   reg [2:0] cur_sel_ff;
   reg [2:0] nxt_cur_sel;
   reg [7:0] cnt_ff;
   reg [7:0] nxt_cnt;
   reg out_ff;
   reg nxt_out;

   always @* begin
      nxt_st = st_ff;
      nxt_cur_sel = cur_sel_ff;
      nxt_cnt = cnt_ff;
      nxt_out = out_ff;
      case (st_ff)
         `COS_ST_HOLD: begin
            nxt_out = 1'b0;
            if (sut_expire && !started_ff) begin
               if (sel_valid(sel_ff)) begin
                  nxt_st = `COS_ST_RUN;
                  nxt_cur_sel = sel_ff;
                  nxt_cnt = half_cyc(sel_ff) - 8'h01;
                  nxt_out = 1'b1;
               end else begin
                  nxt_st = `COS_ST_OFF;
               end
            end
         end
         `COS_ST_RUN: begin
            // a change waits for a low phase so no pulse is cut short
            if (!out_ff && (sel_ff != cur_sel_ff)) begin
               nxt_st = `COS_ST_GAP;
               nxt_cnt = GAP_CYC[7:0] - 8'h01;
            end else if (cnt_ff == 8'h00) begin
               nxt_out = ~out_ff;
               nxt_cnt = half_cyc(cur_sel_ff) - 8'h01;
            end else begin
               nxt_cnt = cnt_ff - 8'h01;
            end
         end
         `COS_ST_GAP: begin
            // low time already spent in run adds to this gap, 9 to 16 clk in all
            nxt_out = 1'b0;
            if (cnt_ff != 8'h00) begin
               nxt_cnt = cnt_ff - 8'h01;
            end else if (sel_valid(sel_ff)) begin
               nxt_st = `COS_ST_RUN;
               nxt_cur_sel = sel_ff;
               nxt_cnt = half_cyc(sel_ff) - 8'h01;
               nxt_out = 1'b1;
            end else begin
               nxt_st = `COS_ST_OFF;
               nxt_cur_sel = sel_ff;
            end
         end
         `COS_ST_OFF: begin
            nxt_out = 1'b0;
            // reserved codes also keep the pin low
            if (sel_valid(sel_ff)) begin
               nxt_st = `COS_ST_GAP;
               nxt_cnt = GAP_CYC[7:0] - 8'h01;
            end
         end
         default: begin
            nxt_st = `COS_ST_OFF;
            nxt_out = 1'b0;
         end
      endcase
   end

   // only power-on reset touches the output: power-down and sys_rst leave it
   always @(posedge clk) begin
      if (rst) begin
         st_ff <= `COS_ST_HOLD;
         cur_sel_ff <= `COS_SEL_RESET;
         cnt_ff <= 8'h00;
         out_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cur_sel_ff <= nxt_cur_sel;
         cnt_ff <= nxt_cnt;
         out_ff <= nxt_out;
      end
   end

   // ---------------- led polarity sense and drive ----------------
   reg a_s1_ff;
   reg a_s2_ff;
   reg b_s1_ff;
   reg b_s2_ff;
   reg sense_pend_ff;
   reg a_src_ff;
   reg b_src_ff;
   reg duplex_ff;
   reg a_o_ff;
   reg b_o_ff;
   reg oe_ff;
   reg [BLINK_W-1:0] blink_ff;
   reg [31:0] str_cnt_ff;
   reg act_ff;
   wire any_rst = rst | sys_rst;
   wire act_now = tx_activity | rx_activity;
   wire fast = blink_ff[BLINK_W-2];
   wire slow = blink_ff[BLINK_W-1];
   // fast and slow blink are the top two bits of a free-running count

   // two-flop synchronisers on the led pins
   always @(posedge clk) begin
      a_s1_ff <= first_led_pin_i;
      a_s2_ff <= a_s1_ff;
      b_s1_ff <= second_led_pin_i;
      b_s2_ff <= b_s1_ff;
   end

   // pins float during reset; external pull reveals the led wiring
   // sys_rst re-senses too, so it must last three edges
   always @(posedge clk) begin
      if (any_rst) begin
         sense_pend_ff <= 1'b1;
         oe_ff <= 1'b0;
         a_src_ff <= 1'b1;
         b_src_ff <= 1'b1;
         duplex_ff <= 1'b0;
      end else if (sense_pend_ff) begin
         sense_pend_ff <= 1'b0;
         a_src_ff <= ~a_s2_ff;
         b_src_ff <= ~b_s2_ff;
         duplex_ff <= b_s2_ff;
         oe_ff <= 1'b1;
      end
   end

   always @(posedge clk) begin
      if (any_rst) begin
         blink_ff <= {BLINK_W{1'b0}};
         str_cnt_ff <= 32'h00000000;
         act_ff <= 1'b0;
      end else begin
         blink_ff <= blink_ff + {{(BLINK_W-1){1'b0}}, 1'b1};
         if (act_now) begin
            str_cnt_ff <= STRETCH_CYC;
            act_ff <= 1'b1;
         end else if (stretch_en && (str_cnt_ff != 32'h00000000)) begin
            str_cnt_ff <= str_cnt_ff - 32'h00000001;
            act_ff <= 1'b1;
         end else begin
            str_cnt_ff <= 32'h00000000;
            act_ff <= 1'b0;
         end
      end
   end

   // source-wired led lights on high, sink-wired on low
   // first cycle after a resense still drives with the reset polarity
   always @(posedge clk) begin
      if (any_rst) begin
         a_o_ff <= 1'b0;
         b_o_ff <= 1'b0;
      end else begin
         a_o_ff <= ~(led_lit(first_led_config, act_ff, fast, slow) ^ a_src_ff);
         b_o_ff <= ~(led_lit(second_led_config, act_ff, fast, slow) ^ b_src_ff);
      end
   end

   // every output comes straight from a flip-flop
   assign ccon_rdata = rdata_ff;
   assign clock_ready_flag = ready_ff;
   assign clock_output_pin = out_ff;
   assign first_led_pin_o = a_o_ff;
   assign first_led_pin_oe = oe_ff;
   assign second_led_pin_o = b_o_ff;
   assign second_led_pin_oe = oe_ff;
   assign duplex_mode_bit = duplex_ff;

endmodule // cos_clock_output_startup_control

/* File: cos_clock_output_startup_control_map.vh */
// constants for the clock output and start-up control block
// What this block does
// - main logic runs from a clock at twice the oscillator rate
// - startup timer counts 7500 oscillator cycles
// - register writes accepted while timer counts
// - timer expiry sets the clock ready flag
// - clock output held low until first expiry
// - first expiry starts output at the selected rate, divide by 4 from reset
// - pin and software reset keep clock output
// - clock output runs through power-down
// - leaving power-down restarts timer, output continues
// - select code 000 drives output low
// - select codes pick divide 1,2,3,4,8
// - no short pulses on any output change
// - output held low 4.5 to 8 oscillator periods
// - control bits 7 to 3 read zero
// - led polarity sensed at reset, then driven
// - later led polarity changes ignored until reset
// - second led polarity sets duplex mode bit
// - no second led gives undefined duplex
// - each led has four-bit config field
// - codes 0111 activity, 1000 on, 1001 off, blinks
`ifndef COS_CLOCK_OUTPUT_STARTUP_CONTROL_MAP_VH
`define COS_CLOCK_OUTPUT_STARTUP_CONTROL_MAP_VH

`define COS_OSC_HZ 25000000
`define COS_CLK_HZ 50000000
`define COS_SUT_OSC_CYCLES 7500
`define COS_SUT_TIME_US 300
`define COS_GAP_OSC_CYCLES 4

`define COS_SEL_W 3
`define COS_SEL_RESET 3'h4
`define COS_SEL_OFF 3'h0
`define COS_SEL_DIV1 3'h1
`define COS_SEL_DIV2 3'h2
`define COS_SEL_DIV3 3'h3
`define COS_SEL_DIV4 3'h4
`define COS_SEL_DIV8 3'h5
`define COS_CTRL_PAD 5'h00

`define COS_DIV1 8'h01
`define COS_DIV2 8'h02
`define COS_DIV3 8'h03
`define COS_DIV4 8'h04
`define COS_DIV8 8'h08

`define COS_LED_ACT 4'h7
`define COS_LED_ON 4'h8
`define COS_LED_OFF 4'h9
`define COS_LED_FAST 4'ha
`define COS_LED_SLOW 4'hb

`define COS_ST_HOLD 2'h0
`define COS_ST_RUN 2'h1
`define COS_ST_GAP 2'h2
`define COS_ST_OFF 2'h3

`endif

/* File: cos_led_load.sv */
// led wiring model on one led pin
module cos_led_load (
   input wire logic sink, // led to supply
   input wire logic drv, // pin drive
   input wire logic oe, // drive enable
   output wire logic pin // wire level
);
   timeunit 1ns;
   timeprecision 1ns;
   // undriven pin rests at the led's pull level
   assign pin = oe ? drv : sink;
endmodule // cos_led_load

/* File: cos_ctl_monitor.sv */
// port assertions for the clock output block
module cos_ctl_monitor #(
   parameter int STARTUP_CYC = 50
) (
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic sys_rst, // pin reset
   input wire logic power_down, // sleep
   input wire logic ccon_wr, // write
   input wire logic [7:0] ccon_wdata, // wdata
   input wire logic [7:0] ccon_rdata, // rdata
   input wire logic clock_ready_flag, // ready
   input wire logic clock_output_pin, // clock_output_pin
   input wire logic second_led_pin_i, // led b
   input wire logic second_led_pin_oe, // led b oe
   input wire logic duplex_mode_bit // duplex
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pd_ff, chg_ff;
   logic [15:0] cnt_ff;
   logic [4:0] lo_ff;
   logic [2:0] old_ff;
   wire [2:0] sel = ccon_rdata[2:0];
   always @(posedge clk) begin
      lo_ff <= clock_output_pin ? 5'h00 : lo_ff + {4'h0, lo_ff != 5'h1f};
      old_ff <= sel;
      if (rst) begin
         pd_ff <= 1'b0;
         chg_ff <= 1'b0;
         cnt_ff <= 16'h0000;
      end else begin
         pd_ff <= pd_ff | power_down;
         cnt_ff <= cnt_ff + {15'h0000, cnt_ff != 16'hffff};
         // only switches away from a running rate
         if (sel != old_ff)
            chg_ff <= old_ff != 3'h0 && old_ff < 3'h6;
         else if (clock_output_pin && lo_ff != 5'h00)
            chg_ff <= 1'b0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_expire;
      !clock_ready_flag ##1 clock_ready_flag;
   endsequence
   property p_pad; ccon_rdata[7:3] == 5'h00; endproperty
   a_pad: assert property (p_pad) else $error("pad bits set");
   property p_wr; ccon_wr |=> sel == $past(ccon_wdata[2:0]); endproperty
   a_wr: assert property (p_wr) else $error("write lost");
   property p_hold; !pd_ff && cnt_ff < STARTUP_CYC |-> !clock_output_pin; endproperty
   a_hold: assert property (p_hold) else $error("early clock");
   property p_boot; !pd_ff && cnt_ff == STARTUP_CYC - 1 |-> s_expire; endproperty
   a_boot: assert property (p_boot) else $error("expiry time");
   property p_wake; $fell(power_down) |-> ##[1:3] !clock_ready_flag; endproperty
   a_wake: assert property (p_wake) else $error("ready kept");
   property p_keep; sys_rst && !ccon_wr |=> $stable(ccon_rdata); endproperty
   a_keep: assert property (p_keep) else $error("control lost");
   property p_off; sel == 3'h0 && $past(sel, 9) == 3'h0 |-> !clock_output_pin; endproperty
   a_off: assert property (p_off) else $error("off not low");
   property p_gap; $rose(clock_output_pin) && chg_ff |-> lo_ff >= 5'h04 && lo_ff <= 5'h10; endproperty
   a_gap: assert property (p_gap) else $error("switch gap");
   property p_led; $fell(rst) |-> ##2 second_led_pin_oe && duplex_mode_bit == $past(second_led_pin_i, 4); endproperty
   a_led: assert property (p_led) else $error("duplex sense");
endmodule // cos_ctl_monitor

/* File: cos_testbench.sv */
// self-checking bench for the clock output block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SUC = 50;
   logic clk = 1'b0, rst = 1'b1, sys_rst = 1'b0, power_down = 1'b0;
   logic ccon_wr = 1'b0, tx_activity = 1'b0, wr_d = 1'b0, sink_a = 1'b0, sink_b = 1'b1;
   logic [7:0] ccon_wdata = 8'h00;
   logic [3:0] cfg_a = 4'h9, cfg_b = 4'h9;
   logic rx_activity = 1'b0, stretch_en = 1'b0;
   logic [1:0] pr;
   logic [7:0] exp_q[$];
   wire [7:0] rdata;
   wire flag, cout, pa, pb, oa, ob, ea, eb, dup;
   integer seed = 32'h9ac2;
   int miscompares = 0, checked = 0, hi;
   cos_clock_output_startup_control #(.STARTUP_CYC(SUC), .STRETCH_CYC(20), .BLINK_W(4)) dut_u (
      .clk(clk), .rst(rst), .sys_rst(sys_rst), .power_down(power_down), .ccon_wr(ccon_wr),
      .ccon_wdata(ccon_wdata), .ccon_rdata(rdata), .clock_ready_flag(flag), .clock_output_pin(cout),
      .first_led_config(cfg_a), .second_led_config(cfg_b), .tx_activity(tx_activity),
      .rx_activity(rx_activity), .stretch_en(stretch_en), .first_led_pin_i(pa), .first_led_pin_o(oa),
      .first_led_pin_oe(ea), .second_led_pin_i(pb), .second_led_pin_o(ob),
      .second_led_pin_oe(eb), .duplex_mode_bit(dup));
   cos_led_load led_a_u (.sink(sink_a), .drv(oa), .oe(ea), .pin(pa));
   cos_led_load led_b_u (.sink(sink_b), .drv(ob), .oe(eb), .pin(pb));
   initial forever #10 clk = ~clk;
   task cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task stop_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task wr(input logic [2:0] s);
      @(posedge clk);
      ccon_wr <= 1'b1;
      ccon_wdata <= {5'($random(seed)), s};
      exp_q.push_back({5'h00, s});
      @(posedge clk);
      ccon_wr <= 1'b0;
   endtask
   // high width of the next whole output pulse
   task meas;
      hi = 0;
      // skip a pulse of the old rate launched on the write's own edge
      @(posedge clk);
      repeat (100) if (cout !== 1'b0) @(posedge clk);
      repeat (100) if (cout !== 1'b1) @(posedge clk);
      while (cout === 1'b1 && hi < 20) begin
         hi++;
         @(posedge clk);
      end
   endtask
   always @(posedge clk) begin
      wr_d <= ccon_wr;
      if (wr_d) cmp(rdata, exp_q.pop_front(), "readback");
   end
   initial begin
      #200000;
      miscompares++;
      stop_test;
   end
   initial begin
      repeat (6) @(posedge clk);
      cmp(rdata, 8'h04, "reset value");
      rst <= 1'b0;
      wr(3'h4);
      repeat (20) @(posedge clk);
      cmp({5'h00, flag, cout, ea & dup}, 8'h01, "startup");
      repeat (2 * SUC) if (flag !== 1'b1) @(posedge clk);
      meas;
      cmp(8'(hi), 8'h04, "default rate");
      $display("test startup done");
      for (int s = 1; s < 6; s++) begin
         wr(3'(s));
         meas;
         cmp(8'(hi), (s == 5) ? 8'h08 : 8'(s), "divider");
      end
      $display("test dividers done");
      sys_rst <= 1'b1;
      meas;
      sys_rst <= 1'b0;
      cmp({flag, hi[6:0]}, 8'h88, "pin reset");
      power_down <= 1'b1;
      meas;
      cmp(8'(hi), 8'h08, "sleep clock");
      power_down <= 1'b0;
      repeat (4) @(posedge clk);
      cmp({7'h00, flag}, 8'h00, "wake");
      meas;
      cmp(8'(hi), 8'h08, "wake clock");
      repeat (2 * SUC) if (flag !== 1'b1) @(posedge clk);
      cmp({7'h00, flag}, 8'h01, "wake expiry");
      $display("test power done");
      wr(3'h0);
      repeat (12) @(posedge clk);
      cmp({7'h00, cout}, 8'h00, "disabled");
      wr(3'h4);
      meas;
      cmp(8'(hi), 8'h04, "enable");
      $display("test disable done");
      for (int c = 7; c < 12; c++) begin
         cfg_a <= 4'(c);
         cfg_b <= 4'(c);
         tx_activity <= (c == 7);
         repeat (4) @(posedge clk);
         if (c < 10) cmp({6'h00, oa, ob}, (c == 9) ? 8'h01 : 8'h02, "led");
         if (c > 9) begin
            pr = {oa, ob};
            repeat (4 * (c - 9)) @(posedge clk);
            cmp({6'h00, oa, ob}, {6'h00, ~pr}, "blink");
         end
      end
      cfg_a <= 4'h7;
      cfg_b <= 4'h7;
      stretch_en <= 1'b1;
      rx_activity <= 1'b1;
      @(posedge clk);
      rx_activity <= 1'b0;
      repeat (10) @(posedge clk);
      cmp({6'h00, oa, ob}, 8'h02, "stretch on");
      repeat (20) @(posedge clk);
      cmp({6'h00, oa, ob}, 8'h01, "stretch off");
      cfg_a <= 4'h8;
      cfg_b <= 4'h8;
      sink_a <= 1'b1;
      sink_b <= 1'b0;
      repeat (4) @(posedge clk);
      cmp({6'h00, oa, ob}, 8'h02, "led kept");
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      cmp({5'h00, dup, oa, ob}, 8'h01, "led resense");
      $display("test leds done");
      stop_test;
   end
endmodule // testbench
bind cos_clock_output_startup_control cos_ctl_monitor #(.STARTUP_CYC(STARTUP_CYC)) mon_u (
   .clk(clk), .rst(rst), .sys_rst(sys_rst), .power_down(power_down), .ccon_wr(ccon_wr),
   .ccon_wdata(ccon_wdata), .ccon_rdata(ccon_rdata), .clock_ready_flag(clock_ready_flag),
   .clock_output_pin(clock_output_pin), .second_led_pin_i(second_led_pin_i),
   .second_led_pin_oe(second_led_pin_oe), .duplex_mode_bit(duplex_mode_bit));
